// ==== ffda_params.svh ====
// offsets, field positions and reset values of the fault flag block
// assumes inclusion by bare name from the package and the top module
`ifndef FFDA_PARAMS_SVH
`define FFDA_PARAMS_SVH

// ********************************
// register offsets
// ********************************
`define FFDA_ADDR_LOD 8'h18
`define FFDA_ADDR_SUM 8'h19
`define FFDA_ADDR_RNG1 8'h1A
`define FFDA_ADDR_RNG2 8'h1B
`define FFDA_ADDR_RNG3 8'h1C
`define FFDA_ADDR_SYNC 8'h1D
`define FFDA_ADDR_MISC 8'h1E
`define FFDA_ADDR_MASK 8'h2A
`define FFDA_ADDR_FILT 8'h2B

// ********************************
// reset values
// ********************************
`define FFDA_RST_MASK 8'h00
`define FFDA_RST_FILT 8'h00

// ********************************
// summary and mask bit positions
// ********************************
`define FFDA_SUM_CM 0
`define FFDA_SUM_RAIL 1
`define FFDA_SUM_SUPPLY 2
`define FFDA_SUM_DETACH 3
`define FFDA_SUM_CH1 4
`define FFDA_SUM_SYNC 7

// ********************************
// channel range, misc and filter fields
// ********************************
`define FFDA_RNG_SIGN 5
`define FFDA_RNG_DIFF_HIGH 6
`define FFDA_MISC_CM 0
`define FFDA_MISC_RAIL 1
`define FFDA_MISC_SUPPLY 2
`define FFDA_FILT_LO_LSB 0
`define FFDA_FILT_HI_LSB 4
`define FFDA_FILT_FIELD_W 4

`endif

// ==== ffda_pkg.sv ====
// types shared by the fault flag block
// assumes the params header sits in the same folder
package ffda_pkg;
  `include "ffda_params.svh"
  typedef logic [7:0] ffda_byte_type;
  typedef logic [`FFDA_FILT_FIELD_W-1:0] ffda_count_type;
endpackage

// ==== ffda_fault_alarm.sv ====
// fault debounce, clear-on-read error registers and open-drain alarm
// assumes raw faults, oscillator and register strobes are synchronous to core_clk
`timescale 1ns/1ps
module ffda_fault_alarm
  import ffda_pkg::*;
#(
  parameter int LOD_W = 6,
  parameter int NCH = 3
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // filter oscillator, sampled
  input wire logic osc_clk,
  // raw analog fault indications
  input wire logic [LOD_W-1:0] detach_raw,
  input wire logic [NCH-1:0][4:0] range_raw,
  input wire logic [NCH-1:0] diff_high_raw,
  input wire logic [NCH-1:0] sign_raw,
  input wire logic cm_range_raw,
  input wire logic near_rail_raw,
  input wire logic supply_low_raw,
  // sync fault events
  input wire logic phase_adjust,
  input wire logic [NCH-1:0] timing_realign,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire ffda_byte_type reg_wdata,
  output ffda_byte_type reg_rdata,
  output logic reg_rvalid,
  // open-drain alarm
  output logic fault_irq_n_o,
  output logic fault_irq_n_oe
);

  // ********************************
  // filter vector layout
  // ********************************
  localparam int CHW = 6;
  localparam int MB = LOD_W + CHW * NCH;
  localparam int FN = MB + 3;

  logic osc_q_r;
  logic tick;
  logic [FN-1:0] raw_vec;
  logic [FN-1:0] flt_r, flt_nxt;
  ffda_count_type cnt_r [FN];
  ffda_count_type cnt_nxt [FN];
  ffda_byte_type mask_r, mask_nxt, filt_r, filt_nxt;
  logic [LOD_W-1:0] lod_r, lod_nxt;
  ffda_byte_type range_r [NCH];
  ffda_byte_type range_nxt [NCH];
  logic [NCH:0] sync_r, sync_nxt, sync_ev;
  logic [2:0] misc_r, misc_nxt;
  ffda_byte_type sum_r, sum_nxt, cond, cond_r, new_v;
  ffda_byte_type rdata_nxt;
  logic oe_nxt;

  // ********************************
  // raw fault gathering
  // ********************************
  always_comb begin
    raw_vec[LOD_W-1:0] = detach_raw;
    for (int c = 0; c < NCH; c++) begin
      raw_vec[LOD_W+CHW*c +: CHW] = {diff_high_raw[c], range_raw[c]};
    end
    raw_vec[MB+`FFDA_MISC_CM] = cm_range_raw;
    raw_vec[MB+`FFDA_MISC_RAIL] = near_rail_raw;
    raw_vec[MB+`FFDA_MISC_SUPPLY] = supply_low_raw;
  end

  // ********************************
  // debounce filters
  // ********************************
  // falling edge of the sampled oscillator is the filter clock
  assign tick = osc_q_r & ~osc_clk;

  always_comb begin
    ffda_count_type lim;
    lim = '0;
    for (int i = 0; i < FN; i++) begin
      cnt_nxt[i] = cnt_r[i];
      flt_nxt[i] = flt_r[i];
      lim = (i < LOD_W) ? filt_r[`FFDA_FILT_LO_LSB +: `FFDA_FILT_FIELD_W]
                        : filt_r[`FFDA_FILT_HI_LSB +: `FFDA_FILT_FIELD_W];
      if (!raw_vec[i]) begin
        cnt_nxt[i] = '0;
        flt_nxt[i] = 1'b0;
      end else if (tick) begin
        // code n passes on the (n+1)th active tick
        if (cnt_r[i] >= lim) begin
          flt_nxt[i] = 1'b1;
        end else begin
          cnt_nxt[i] = ffda_count_type'(cnt_r[i] + 4'h1);
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_q_r <= 1'b0;
      flt_r <= '0;
      for (int i = 0; i < FN; i++) begin
        cnt_r[i] <= '0;
      end
    end else begin
      osc_q_r <= osc_clk;
      flt_r <= flt_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ********************************
  // error registers
  // ********************************
  function automatic logic rd_hit(input logic [7:0] a);
    rd_hit = reg_rd && (reg_addr == a);
  endfunction

  assign sync_ev = {timing_realign, phase_adjust};

  always_comb begin
    logic clr;
    logic [CHW-1:0] f;
    clr = 1'b0;
    f = '0;
    // set wins over the read clear so no fault slips between
    lod_nxt = (rd_hit(`FFDA_ADDR_LOD) ? '0 : lod_r) | flt_r[LOD_W-1:0];
    misc_nxt = (rd_hit(`FFDA_ADDR_MISC) ? 3'h0 : misc_r) | flt_r[MB +: 3];
    sync_nxt = (rd_hit(`FFDA_ADDR_SYNC) ? '0 : sync_r) | sync_ev;
    for (int c = 0; c < NCH; c++) begin
      clr = rd_hit(8'(`FFDA_ADDR_RNG1 + c));
      f = flt_r[LOD_W+CHW*c +: CHW];
      range_nxt[c] = clr ? 8'h00 : range_r[c];
      // compare against the post-clear bit so a read never loses the sign
      if (f[5] && !range_nxt[c][`FFDA_RNG_DIFF_HIGH]) begin
        range_nxt[c][`FFDA_RNG_SIGN] = sign_raw[c];
      end
      range_nxt[c][4:0] = range_nxt[c][4:0] | f[4:0];
      range_nxt[c][`FFDA_RNG_DIFF_HIGH] = range_nxt[c][`FFDA_RNG_DIFF_HIGH] | f[5];
    end
  end

  // ********************************
  // summary, new fault detect, alarm
  // ********************************
  always_comb begin
    cond = '0;
    cond[`FFDA_SUM_CM] = flt_r[MB+`FFDA_MISC_CM];
    cond[`FFDA_SUM_RAIL] = flt_r[MB+`FFDA_MISC_RAIL];
    cond[`FFDA_SUM_SUPPLY] = flt_r[MB+`FFDA_MISC_SUPPLY];
    cond[`FFDA_SUM_DETACH] = |flt_r[LOD_W-1:0];
    for (int c = 0; c < NCH; c++) begin
      cond[`FFDA_SUM_CH1+c] = |flt_r[LOD_W+CHW*c +: CHW];
    end
    cond[`FFDA_SUM_SYNC] = |sync_ev;
    // edges only: a persisting fault cannot re-arm the alarm
    new_v = cond & ~cond_r;
    sum_nxt = (rd_hit(`FFDA_ADDR_SUM) ? 8'h00 : sum_r) | new_v;
    oe_nxt = |(sum_nxt & ~mask_r);
  end

  // ********************************
  // register port
  // ********************************
  always_comb begin
    mask_nxt = mask_r;
    filt_nxt = filt_r;
    if (reg_wr && reg_addr == `FFDA_ADDR_MASK) begin
      mask_nxt = reg_wdata;
    end
    if (reg_wr && reg_addr == `FFDA_ADDR_FILT) begin
      filt_nxt = reg_wdata;
    end
    rdata_nxt = reg_rdata;
    if (reg_rd) begin
      unique case (reg_addr)
        `FFDA_ADDR_LOD: rdata_nxt = 8'(lod_r);
        `FFDA_ADDR_SUM: rdata_nxt = sum_r;
        `FFDA_ADDR_RNG1: rdata_nxt = range_r[0];
        `FFDA_ADDR_RNG2: rdata_nxt = range_r[1];
        `FFDA_ADDR_RNG3: rdata_nxt = range_r[2];
        `FFDA_ADDR_SYNC: rdata_nxt = 8'(sync_r);
        `FFDA_ADDR_MISC: rdata_nxt = 8'(misc_r);
        `FFDA_ADDR_MASK: rdata_nxt = mask_r;
        `FFDA_ADDR_FILT: rdata_nxt = filt_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      lod_r <= '0;
      misc_r <= '0;
      sync_r <= '0;
      for (int c = 0; c < NCH; c++) begin
        range_r[c] <= 8'h00;
      end
      sum_r <= 8'h00;
      cond_r <= 8'h00;
      mask_r <= `FFDA_RST_MASK;
      filt_r <= `FFDA_RST_FILT;
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
      fault_irq_n_o <= 1'b0;
      fault_irq_n_oe <= 1'b0;
    end else begin
      lod_r <= lod_nxt;
      misc_r <= misc_nxt;
      sync_r <= sync_nxt;
      range_r <= range_nxt;
      sum_r <= sum_nxt;
      cond_r <= cond;
      mask_r <= mask_nxt;
      filt_r <= filt_nxt;
      reg_rdata <= rdata_nxt;
      reg_rvalid <= reg_rd;
      // open drain: the pin only ever pulls low
      fault_irq_n_o <= 1'b0;
      fault_irq_n_oe <= oe_nxt;
    end
  end

  // ********************************
  // assertions
  // ********************************
  int unsigned act_cnt;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      act_cnt <= 0;
    end else if (!supply_low_raw) begin
      act_cnt <= 0;
    end else if (tick && act_cnt < 32) begin
      act_cnt <= act_cnt + 1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  property p_ch_sum;
    (|flt_r[LOD_W +: CHW]) && !cond_r[`FFDA_SUM_CH1] |=> sum_r[`FFDA_SUM_CH1];
  endproperty
  a_ch_sum: assert property (p_ch_sum) else $error("channel summary not set");

  property p_detach_sum;
    $rose(|flt_r[LOD_W-1:0]) |=> sum_r[`FFDA_SUM_DETACH] && lod_r != '0;
  endproperty
  a_detach_sum: assert property (p_detach_sum) else $error("detach summary missing");

  property p_supply_alarm;
    sum_r[`FFDA_SUM_SUPPLY] && !mask_r[`FFDA_SUM_SUPPLY] && $stable(mask_r)
      |-> fault_irq_n_oe;
  endproperty
  a_supply_alarm: assert property (p_supply_alarm) else $error("supply alarm missing");

  property p_debounce;
    flt_r[MB+`FFDA_MISC_SUPPLY] |-> act_cnt >= int'(filt_r[7:4]) + 1;
  endproperty
  a_debounce: assert property (p_debounce) else $error("fault accepted too early");

  property p_tick_edge;
    $rose(flt_r[0]) |-> $past(tick);
  endproperty
  a_tick_edge: assert property (p_tick_edge) else $error("filter moved off tick");

  property p_restart;
    !raw_vec[0] |=> cnt_r[0] == '0 && !flt_r[0];
  endproperty
  a_restart: assert property (p_restart) else $error("counter not restarted");

  property p_mask_fall;
    $rose(fault_irq_n_oe) |-> |(sum_r & ~$past(mask_r));
  endproperty
  a_mask_fall: assert property (p_mask_fall) else $error("masked fault hit alarm");

  property p_hold;
    lod_r[0] && !rd_hit(`FFDA_ADDR_LOD) |=> lod_r[0];
  endproperty
  a_hold: assert property (p_hold) else $error("latched bit dropped");

  property p_sign;
    $rose(range_r[0][`FFDA_RNG_DIFF_HIGH]) |-> range_r[0][`FFDA_RNG_SIGN] == $past(sign_raw[0]);
  endproperty
  a_sign: assert property (p_sign) else $error("sign not captured");

  property p_return;
    rd_hit(`FFDA_ADDR_LOD) && flt_r[0] && raw_vec[0] |-> ##[1:2] lod_r[0];
  endproperty
  a_return: assert property (p_return) else $error("persisting fault lost");

  property p_no_rearm;
    rd_hit(`FFDA_ADDR_SUM) && cond_r[`FFDA_SUM_DETACH] && cond[`FFDA_SUM_DETACH]
      |=> !sum_r[`FFDA_SUM_DETACH];
  endproperty
  a_no_rearm: assert property (p_no_rearm) else $error("summary rearmed");

  property p_sync;
    phase_adjust |=> sync_r[0] && sum_r[`FFDA_SUM_SYNC] | cond_r[`FFDA_SUM_SYNC];
  endproperty
  a_sync: assert property (p_sync) else $error("sync fault not latched");

  property p_release;
    rd_hit(`FFDA_ADDR_SUM) && new_v == 8'h00 |=> !fault_irq_n_oe && sum_r == 8'h00;
  endproperty
  a_release: assert property (p_release) else $error("alarm not released");

  c_alarm: cover property ($rose(fault_irq_n_oe));
  c_release: cover property (fault_irq_n_oe ##1 rd_hit(`FFDA_ADDR_SUM) ##1 !fault_irq_n_oe);
  c_return: cover property (rd_hit(`FFDA_ADDR_LOD) && flt_r[0] ##2 lod_r[0]);
  c_sign: cover property ($rose(range_r[1][`FFDA_RNG_DIFF_HIGH]));

endmodule

// ==== ffda_fault_alarm_tail.sv ====
`timescale 1ns/1ps

// ==== ffda_host_model.sv ====
// host model: register reads and writes, alarm pin with pull-up
// assumes calls from the falling clock edge, one transfer at a time
`timescale 1ns/1ps
module ffda_host_model
  import ffda_pkg::*;
(
  // clock
  input wire logic core_clk,
  // register port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output ffda_byte_type reg_wdata,
  input wire ffda_byte_type reg_rdata,
  input wire logic reg_rvalid,
  // alarm pin
  input wire logic fault_irq_n_o,
  input wire logic fault_irq_n_oe,
  output logic alarm_pin_n
);
  // ************************
  // pin and bus
  // ************************
  // board pull-up: a released pin reads high
  assign alarm_pin_n = fault_irq_n_oe ? fault_irq_n_o : 1'b1;
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input ffda_byte_type d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    // idle bus shows no stale value
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
    // one idle edge, so the next call never reassigns in this time step
    @(negedge core_clk);
  endtask
  // the summary read is what releases the alarm
  task automatic rd(input logic [7:0] a, output ffda_byte_type d, output logic ok);
    int i;
    reg_addr = a;
    reg_rd = 1'b1;
    ok = 1'b0;
    d = 8'h00;
    @(negedge core_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    for (i = 0; i < 4 && !ok; i++) begin
      if (reg_rvalid === 1'b1) begin
        d = reg_rdata;
        ok = 1'b1;
      end else begin
        @(negedge core_clk);
      end
    end
    @(negedge core_clk);
  endtask
endmodule

// ==== fault_flag_debounce_alarm_test.sv ====
// bench for the fault flag block with the host model on its register port
// assumes the params header in the same folder
`timescale 1ns/1ps
`include "ffda_params.svh"
module fault_flag_debounce_alarm_test
  import ffda_pkg::*;
;
  // ************************
  // signals
  // ************************
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic osc_clk = 1'b0;
  logic [5:0] detach_raw = 6'h00;
  logic [2:0][4:0] range_raw = '0;
  logic [2:0] diff_high_raw = 3'h0;
  logic [2:0] sign_raw = 3'h0;
  logic cm_range_raw = 1'b0;
  logic near_rail_raw = 1'b0;
  logic supply_low_raw = 1'b0;
  logic phase_adjust = 1'b0;
  logic [2:0] timing_realign = 3'h0;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  ffda_byte_type reg_wdata;
  ffda_byte_type reg_rdata;
  logic reg_rvalid;
  logic fault_irq_n_o;
  logic fault_irq_n_oe;
  logic alarm_pin_n;
  int mismatches = 0;
  int check_count = 0;
  always #2.5 core_clk = ~core_clk;
  ffda_fault_alarm #(.LOD_W(6), .NCH(3)) ffda_fault_alarm_inst (.core_clk(core_clk),
    .reset_n(reset_n), .osc_clk(osc_clk), .detach_raw(detach_raw), .range_raw(range_raw),
    .diff_high_raw(diff_high_raw), .sign_raw(sign_raw), .cm_range_raw(cm_range_raw),
    .near_rail_raw(near_rail_raw), .supply_low_raw(supply_low_raw),
    .phase_adjust(phase_adjust), .timing_realign(timing_realign), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .fault_irq_n_o(fault_irq_n_o), .fault_irq_n_oe(fault_irq_n_oe));
  ffda_host_model ffda_host_model_inst (.core_clk(core_clk), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .fault_irq_n_o(fault_irq_n_o),
    .fault_irq_n_oe(fault_irq_n_oe), .alarm_pin_n(alarm_pin_n));
  // ************************
  // shared tasks
  // ************************
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    ffda_byte_type d;
    logic ok;
    ffda_host_model_inst.rd(a, d, ok);
    if (!ok) begin
      mismatches++;
      report_and_stop();
    end
    check(d, exp);
  endtask
  task automatic pin(input logic e);
    check({7'h00, alarm_pin_n}, {7'h00, e});
  endtask
  // slow oscillator: n falling edges, each followed by time for the flags to land
  task automatic ticks(input int n);
    repeat (n) begin
      osc_clk = 1'b1;
      repeat (2) @(negedge core_clk);
      osc_clk = 1'b0;
      repeat (4) @(negedge core_clk);
    end
  endtask
  task automatic pulse_sync(input logic ph, input logic [2:0] tm);
    phase_adjust = ph;
    timing_realign = tm;
    @(negedge core_clk);
    phase_adjust = 1'b0;
    timing_realign = 3'h0;
    @(negedge core_clk);
  endtask
  // ************************
  // scenarios
  // ************************
  task automatic t_regs();
    rdc(`FFDA_ADDR_MASK, `FFDA_RST_MASK);
    rdc(`FFDA_ADDR_FILT, `FFDA_RST_FILT);
    rdc(8'h40, 8'h00);
    ffda_host_model_inst.wr(`FFDA_ADDR_FILT, 8'h20);
    rdc(`FFDA_ADDR_FILT, 8'h20);
  endtask
  task automatic t_filter();
    supply_low_raw = 1'b1;
    ticks(2);
    pin(1'b1);
    ticks(1);
    pin(1'b0);
    rdc(`FFDA_ADDR_MISC, 8'h04);
    rdc(`FFDA_ADDR_SUM, 8'h04);
    pin(1'b1);
    rdc(`FFDA_ADDR_SUM, 8'h00);
    ticks(1);
    rdc(`FFDA_ADDR_MISC, 8'h04);
    pin(1'b1);
    supply_low_raw = 1'b0;
    ticks(1);
    rdc(`FFDA_ADDR_MISC, 8'h04);
    rdc(`FFDA_ADDR_MISC, 8'h00);
  endtask
  task automatic t_restart();
    supply_low_raw = 1'b1;
    ticks(2);
    supply_low_raw = 1'b0;
    ticks(1);
    supply_low_raw = 1'b1;
    ticks(2);
    pin(1'b1);
    ticks(1);
    pin(1'b0);
    rdc(`FFDA_ADDR_SUM, 8'h04);
    supply_low_raw = 1'b0;
    ticks(1);
  endtask
  task automatic t_detach();
    detach_raw = 6'h09;
    ticks(1);
    pin(1'b0);
    rdc(`FFDA_ADDR_LOD, 8'h09);
    rdc(`FFDA_ADDR_LOD, 8'h09);
    rdc(`FFDA_ADDR_SUM, 8'h08);
    detach_raw = 6'h00;
    ticks(1);
    rdc(`FFDA_ADDR_LOD, 8'h09);
    rdc(`FFDA_ADDR_LOD, 8'h00);
  endtask
  task automatic t_mask();
    ffda_host_model_inst.wr(`FFDA_ADDR_MASK, 8'h04);
    supply_low_raw = 1'b1;
    ticks(3);
    pin(1'b1);
    rdc(`FFDA_ADDR_SUM, 8'h04);
    pulse_sync(1'b1, 3'h0);
    pin(1'b0);
    rdc(`FFDA_ADDR_SYNC, 8'h01);
    rdc(`FFDA_ADDR_SUM, 8'h80);
    pulse_sync(1'b0, 3'h2);
    rdc(`FFDA_ADDR_SYNC, 8'h04);
    rdc(`FFDA_ADDR_SUM, 8'h80);
    ffda_host_model_inst.wr(`FFDA_ADDR_MASK, 8'h80);
    pulse_sync(1'b0, 3'h1);
    pin(1'b1);
    rdc(`FFDA_ADDR_SYNC, 8'h02);
    supply_low_raw = 1'b0;
    ffda_host_model_inst.wr(`FFDA_ADDR_MASK, 8'h00);
    rdc(`FFDA_ADDR_SUM, 8'h80);
    rdc(`FFDA_ADDR_MISC, 8'h04);
  endtask
  task automatic t_range();
    sign_raw = 3'h2;
    diff_high_raw = 3'h3;
    range_raw[2] = 5'h01;
    cm_range_raw = 1'b1;
    near_rail_raw = 1'b1;
    ticks(3);
    pin(1'b0);
    rdc(`FFDA_ADDR_RNG1, 8'h40);
    rdc(`FFDA_ADDR_RNG2, 8'h60);
    rdc(`FFDA_ADDR_RNG2, 8'h60);
    rdc(`FFDA_ADDR_RNG3, 8'h01);
    rdc(`FFDA_ADDR_MISC, 8'h03);
    rdc(`FFDA_ADDR_SUM, 8'h73);
    pin(1'b1);
  endtask
  // ************************
  // main sequence
  // ************************
  initial begin
    repeat (10) @(negedge core_clk);
    reset_n = 1'b1;
    @(negedge core_clk);
    pin(1'b1);
    t_regs();
    t_filter();
    t_restart();
    t_detach();
    t_mask();
    t_range();
    report_and_stop();
  end
endmodule
